/* src/rpb_pkg.sv */
// Package for the RF port and bias switch control block
// How it works
// R1: Bit 12 selects port mode, 0 dual
// R2: Single port: internal switch, shared pins bidirectional
// R3: Dual port: input pair receives, PA pair transmits
// R4: Bit 14 enables output, else high impedance
// R5: Single port: high for TX, low RX
// R6: Bit 13 inverts, dual port enabled only
// R7: Dual port: TX 1, RX 0, inverted if set
// R8: Idle, Doze, Hibernate drive low when enabled
// R9: Host configures register 07 before relying output
// R10: Single port: RX routes LNA, TX enables PA
// R11: Dual port: shared-pin PA always disabled
// R12: Reset clears all three control bits
package rpb_pkg;
	// Register index; byte address is four times it
	localparam int          RPB_CTRL_INDEX   = 7;
	localparam int          RPB_WORD_BYTES   = 4;
	localparam logic [31:0] RPB_CTRL_ADDR    =
		32'(RPB_CTRL_INDEX * RPB_WORD_BYTES);
	localparam logic [31:0] RPB_STATUS_ADDR  = 32'h00000020;
	localparam logic [31:0] RPB_RADIO_ADDR   = 32'h00000024;
	localparam int          RPB_MODE_BIT     = 12;
	localparam int          RPB_INV_BIT      = 13;
	localparam int          RPB_EN_BIT       = 14;
	localparam logic [15:0] RPB_CTRL_RESET   = 16'h0000;
	localparam logic [15:0] RPB_CTRL_MASK    = 16'h7000;
	localparam logic [31:0] RPB_SLVERR_DATA  = 32'h00000000;

	typedef enum logic [2:0] {
		RPB_OFF, RPB_IDLE, RPB_DOZE, RPB_HIBERNATE, RPB_RX, RPB_TX
	} rpb_radio_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] paddr;
		logic [31:0] pwdata;
	} rpb_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} rpb_apb_rsp_type;

	typedef struct packed {
		logic lna_path_on;
		logic shared_pa_on;
		logic dedicated_pa_on;
		logic switch_single;
		logic bias_level;
		logic bias_oe;
	} rpb_rf_type;

	typedef struct packed {
		logic [15:0]     ctrl;
		rpb_radio_type   radio;
		rpb_radio_type   radio_meta;
		rpb_radio_type   radio_sync;
		rpb_radio_type   radio_hold;
		rpb_apb_rsp_type rsp;
		rpb_rf_type      rf;
	} rpb_state_type;
endpackage : rpb_pkg

/* src/rpb_top.sv */
// RF port mode and bias switch output control with APB registers
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
module rpb_top (
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire rpb_pkg::rpb_apb_req_type apb_req,
	output rpb_pkg::rpb_apb_rsp_type      apb_rsp,
	// Radio state from the modem core, asynchronous
	input  wire rpb_pkg::rpb_radio_type   radio_state,
	// RF front end controls
	output rpb_pkg::rpb_rf_type           rf_ctrl
);
	import rpb_pkg::*;

	// Whole block state, registered in one place
	rpb_state_type s_r;
	rpb_state_type s_nxt;

	// Control bits of the current register value
	logic          en;
	logic          single;
	logic          inv;

	// Bus phase decode
	logic          setup_phase;
	logic          access_done;
	logic          hit_ctrl;
	logic          hit_status;
	logic          hit_radio;

	// Settled radio state
	logic          radio_steady;

	always_comb begin
		s_nxt = s_r;

		// Control bits
		en = s_r.ctrl[RPB_EN_BIT];
		single = s_r.ctrl[RPB_MODE_BIT];
		inv = s_r.ctrl[RPB_INV_BIT];

		// Three flops in a chain on the asynchronous radio word
		s_nxt.radio_meta = radio_state;
		s_nxt.radio_sync = s_r.radio_meta;
		s_nxt.radio_hold = s_r.radio_sync;

		// Word taken only when two samples agree, so a
		// skewed change between bits never reaches the outputs
		radio_steady = (s_r.radio_sync == s_r.radio_hold);
		if (radio_steady) begin
			s_nxt.radio = s_r.radio_hold;
		end

		// Bus phases
		setup_phase = apb_req.psel && !apb_req.penable;
		access_done = apb_req.psel && apb_req.penable
			&& s_r.rsp.pready;

		// Address decode
		hit_ctrl = 1'b0;
		hit_status = 1'b0;
		hit_radio = 1'b0;
		if (apb_req.paddr == RPB_CTRL_ADDR) begin
			hit_ctrl = 1'b1;
		end else if (apb_req.paddr == RPB_STATUS_ADDR) begin
			hit_status = 1'b1;
		end else if (apb_req.paddr == RPB_RADIO_ADDR) begin
			hit_radio = 1'b1;
		end

		// Answer registered at the setup edge, shown in the access cycle
		s_nxt.rsp.pready = 1'b0;
		s_nxt.rsp.pslverr = 1'b0;
		s_nxt.rsp.prdata = RPB_SLVERR_DATA;
		if (setup_phase) begin
			s_nxt.rsp.pready = 1'b1;
			if (hit_ctrl) begin
				if (!apb_req.pwrite) begin
					s_nxt.rsp.prdata = {16'h0000, s_r.ctrl};
				end
			end else if (hit_status) begin
				s_nxt.rsp.pslverr = apb_req.pwrite;
				if (!apb_req.pwrite) begin
					s_nxt.rsp.prdata = {26'h0000000, s_r.rf};
				end
			end else if (hit_radio) begin
				s_nxt.rsp.pslverr = apb_req.pwrite;
				if (!apb_req.pwrite) begin
					s_nxt.rsp.prdata = {29'h00000000, s_r.radio};
				end
			end else begin
				s_nxt.rsp.pslverr = 1'b1;
			end
		end

		// Write lands only at the edge that completes the access
		if (access_done && apb_req.pwrite && hit_ctrl) begin
			s_nxt.ctrl = apb_req.pwdata[15:0] & RPB_CTRL_MASK; // see R1
		end

		// Port mode shown to the front end
		s_nxt.rf.switch_single = single; // see R2

		// Paths and bias level per radio state
		case (s_r.radio)
			RPB_TX: begin
				s_nxt.rf.lna_path_on = 1'b0;
				s_nxt.rf.shared_pa_on = single; // see R2 see R10
				s_nxt.rf.dedicated_pa_on = !single; // see R3 see R11
				if (single) begin
					s_nxt.rf.bias_level = 1'b1; // see R5
				end else begin
					s_nxt.rf.bias_level = !inv; // see R6 see R7
				end
			end
			RPB_RX: begin
				s_nxt.rf.lna_path_on = 1'b1; // see R10
				s_nxt.rf.shared_pa_on = 1'b0;
				s_nxt.rf.dedicated_pa_on = 1'b0;
				if (single) begin
					s_nxt.rf.bias_level = 1'b0; // see R5
				end else begin
					s_nxt.rf.bias_level = inv; // see R6 see R7
				end
			end
			RPB_IDLE: begin
				s_nxt.rf.lna_path_on = 1'b0;
				s_nxt.rf.shared_pa_on = 1'b0;
				s_nxt.rf.dedicated_pa_on = 1'b0;
				s_nxt.rf.bias_level = 1'b0; // see R8
			end
			RPB_DOZE: begin
				s_nxt.rf.lna_path_on = 1'b0;
				s_nxt.rf.shared_pa_on = 1'b0;
				s_nxt.rf.dedicated_pa_on = 1'b0;
				s_nxt.rf.bias_level = 1'b0; // see R8
			end
			RPB_HIBERNATE: begin
				// Held low and actively driven while bit 14 enables the output
				s_nxt.rf.lna_path_on = 1'b0;
				s_nxt.rf.shared_pa_on = 1'b0;
				s_nxt.rf.dedicated_pa_on = 1'b0;
				s_nxt.rf.bias_level = 1'b0; // see R8
			end
			RPB_OFF: begin
				// Level undefined for the radio; low is the safe pick
				s_nxt.rf.lna_path_on = 1'b0;
				s_nxt.rf.shared_pa_on = 1'b0;
				s_nxt.rf.dedicated_pa_on = 1'b0;
				s_nxt.rf.bias_level = 1'b0;
			end
			default: begin
				s_nxt.rf.lna_path_on = 1'b0;
				s_nxt.rf.shared_pa_on = 1'b0;
				s_nxt.rf.dedicated_pa_on = 1'b0;
				s_nxt.rf.bias_level = 1'b0;
			end
		endcase

		// Output enable; level forced low while the pin floats
		s_nxt.rf.bias_oe = en; // see R4
		if (!en) begin
			s_nxt.rf.bias_level = 1'b0; // see R4
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0; // see R12
		end else begin
			s_r <= s_nxt;
		end
	end

	assign apb_rsp = s_r.rsp;
	assign rf_ctrl = s_r.rf;
endmodule : rpb_top

/* sim/rpb_sva.sv */
// Port checks of the bias switch block
`timescale 1ns/1ns
module rpb_sva import rpb_pkg::*; (
	input wire logic             pclk,
	input wire logic             presetn,
	input wire rpb_apb_req_type  apb_req,
	input wire rpb_apb_rsp_type  apb_rsp,
	input wire rpb_radio_type    radio_state,
	input wire rpb_rf_type       rf_ctrl
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rdy; apb_req.psel && !apb_req.penable |=> apb_rsp.pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_one; apb_rsp.pready |=> !apb_rsp.pready; endproperty
	a_one: assert property (p_one) else $error("ready too long");
	property p_rd0; !apb_rsp.pready |-> apb_rsp.prdata == 0; endproperty
	a_rd0: assert property (p_rd0) else $error("stray data");
	property p_hiz; !rf_ctrl.bias_oe |-> !rf_ctrl.bias_level; endproperty
	a_hiz: assert property (p_hiz) else $error("level off");
	property p_sp; rf_ctrl.bias_oe && rf_ctrl.switch_single |->
		rf_ctrl.bias_level == rf_ctrl.shared_pa_on; endproperty
	a_sp: assert property (p_sp) else $error("single level");
	property p_low; rf_ctrl.bias_oe && !rf_ctrl.lna_path_on &&
		!rf_ctrl.shared_pa_on && !rf_ctrl.dedicated_pa_on |->
		!rf_ctrl.bias_level; endproperty
	a_low: assert property (p_low) else $error("not low");
	property p_pa; rf_ctrl.shared_pa_on |-> rf_ctrl.switch_single;
	endproperty
	a_pa: assert property (p_pa) else $error("shared pa");
	property p_lna; rf_ctrl.lna_path_on |->
		!rf_ctrl.shared_pa_on && !rf_ctrl.dedicated_pa_on; endproperty
	a_lna: assert property (p_lna) else $error("pa in rx");
	c_sp: cover property (rf_ctrl.shared_pa_on);
	c_dp: cover property (rf_ctrl.dedicated_pa_on);
	c_err: cover property (apb_rsp.pslverr);
endmodule : rpb_sva
bind rpb_top rpb_sva u_sva (.*);

/* sim/rpb_fe_model.sv */
// Balun or antenna switch seen through the bias pin
`timescale 1ns/1ns
module rpb_fe_model (
	input wire logic pclk,
	input wire logic oe,
	input wire logic lvl,
	output logic     pin
);
	// Floating pin wanders so a stale level never passes
	always @(posedge pclk) pin <= oe ? lvl : ~pin;
endmodule : rpb_fe_model

/* sim/tb_top.sv */
// Random bench of the bias switch block
`timescale 1ns/1ns
module tb_top;
	import rpb_pkg::*;
	logic pclk, presetn, pin;
	logic [32:0] d;
	logic [2:0] c;
	rpb_apb_req_type rq;
	rpb_apb_rsp_type rs;
	rpb_radio_type rad;
	rpb_rf_type rf;
	int miscompares, n_tests, cyc, seed = 56;
	rpb_top dut_u (.pclk(pclk), .presetn(presetn), .apb_req(rq),
		.apb_rsp(rs), .radio_state(rad), .rf_ctrl(rf));
	rpb_fe_model fe_u (.pclk(pclk), .oe(rf.bias_oe), .lvl(rf.bias_level),
		.pin(pin));
	initial begin pclk = 0; forever #20 pclk = ~pclk; end
	always @(posedge pclk) if (++cyc > 3000) begin miscompares++; stop_test; end
	task automatic cmp(logic [32:0] g, e);
		n_tests++;
		if (g !== e) begin miscompares++;
			$display("unexpected %0t %h %h", $time, g, e); end
	endtask : cmp
	task automatic apb(logic w, logic [31:0] a, v, output logic [32:0] q);
		@(posedge pclk) rq <= '{1'b1, 1'b0, w, a, v};
		@(posedge pclk) rq.penable <= 1'b1;
		@(posedge pclk iff rs.pready) q = {rs.pslverr, rs.prdata};
		rq <= '0;
	endtask : apb
	function automatic logic expb(logic [2:0] k, rpb_radio_type r);
		if (r == RPB_TX) return k[0] | !k[1];
		if (r == RPB_RX) return !k[0] & k[1];
		return 1'b0;
	endfunction : expb
	function automatic rpb_rf_type exprf(logic [2:0] k, rpb_radio_type r);
		rpb_rf_type e;
		e = '0;
		e.switch_single = k[0];
		e.bias_oe = k[2];
		e.lna_path_on = (r == RPB_RX);
		e.shared_pa_on = k[0] && (r == RPB_TX);
		e.dedicated_pa_on = !k[0] && (r == RPB_TX);
		e.bias_level = k[2] & expb(k, r);
		return e;
	endfunction : exprf
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		rq = '0; rad = RPB_OFF; presetn = 0; cyc = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, RPB_CTRL_ADDR, 0, d);
		cmp(d, 0);
		apb(1, 32'h30, 0, d);
		cmp(d, 33'h100000000);
		apb(1, RPB_STATUS_ADDR, 32'hFFFFFFFF, d);
		cmp(d, 33'h100000000);
		apb(1, RPB_CTRL_ADDR, 32'hFFFFFFFF, d);
		apb(0, RPB_CTRL_ADDR, 0, d);
		cmp(d, 33'(RPB_CTRL_MASK));
		repeat (40) begin
			@(posedge pclk) rad <= rpb_radio_type'(3'($unsigned($random(seed)) % 6));
			c = 3'($random(seed));
			apb(1, RPB_CTRL_ADDR, {17'h0, c, 12'h000}, d);
			repeat (6) @(posedge pclk);
			@(negedge pclk) cmp(33'(rf), 33'(exprf(c, rad)));
			cmp(pin & rf.bias_oe, c[2] & expb(c, rad));
			apb(0, RPB_CTRL_ADDR, 0, d);
			cmp(d, {17'h0, c, 12'h000});
			apb(0, RPB_STATUS_ADDR, 0, d);
			cmp(d, 33'(exprf(c, rad)));
			apb(0, RPB_RADIO_ADDR, 0, d);
			cmp(d, 33'(rad));
		end
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk) cmp(33'(rf), 33'(0));
		apb(0, RPB_CTRL_ADDR, 0, d);
		cmp(d, 0);
		stop_test;
	end
endmodule : tb_top
